//--- hw/converter_host_glue.sv
/*
 * Host glue for a sampling converter: starts conversions, latches completion,
 * reads the result over the converter pins into a FIFO, and answers port reads.
 * Assumes the converter drives conversion done and the result bus asynchronously,
 * and the host holds its I/O strobe until io_ready is seen high.
 */
// Summary of operation
// - In synchronous mode a write to port 8 produces a start pulse for the converter.
// - A read of port 8 returns completion status and the result.
// - Each port 8 access is given exactly one wait state through io_ready.
// - At 40 MHz the host follows each converter read with a spare cycle.
// - In asynchronous mode only the external trigger starts conversions.
// - Each completion raises the DMA request line.
// - The pending latch is cleared by the result read that follows it.
// - Requests must be drained before the next conversion completes.
// - Byte flag goes low first; the high-byte read starts next cycle.
// - The result read sequencer produces the converter output enable.
// - Each byte read lasts the full 160 ns read window.
// - Byte flag then goes high and the low byte is read the same way.
// - Upper byte select is released as the high-byte read starts.
// - Output enable stays low for the 7 cycles of each byte read.
// - Start pulses are spaced at least 5 us apart, never held low.
`timescale 1ns/1ps
module converter_host_glue #(
    parameter int RESULT_W   = glue_pkg::RESULT_W,
    parameter int FIFO_DEPTH = glue_pkg::FIFO_DEPTH
) (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  io_rd,
    input  wire logic                  io_wr,
    input  wire logic [7:0]            io_addr,
    output logic                       io_ready,
    output logic [glue_pkg::RDATA_W-1:0] io_rdata,
    output logic                       io_rvalid,
    input  wire logic                  async_mode,
    input  wire logic                  ext_trigger,
    input  wire logic                  wide_mode,
    input  wire logic                  conv_done,
    input  wire logic [RESULT_W-1:0]   result_bus,
    output logic                       convert_start_n,
    output logic                       output_enable_n,
    output logic                       host_flag_output,
    output logic                       upper_byte_select_n,
    output logic                       read_width_12,
    output logic                       dma_request_channel_one,
    output logic                       irq,
    output logic                       start_refused,
    output logic                       overrun
);
    // ------------------------------------------------------------
    // Elaboration checks and local types
    // ------------------------------------------------------------
    if (RESULT_W != int'(glue_pkg::RESULT_W)) begin : g_bad_width
        $error("converter_host_glue supports only the 12-bit result layout");
    end

    localparam int BW = $clog2(glue_pkg::BYTE_READ_CYC + 1);

    typedef enum logic [2:0] {
        R_IDLE,
        R_HI_SEL,
        R_HI,
        R_LO_SEL,
        R_LO,
        R_PUSH
    } rd_state_e;

    // Decode of the converter port, used for reads and writes.
    function automatic logic port_hit(input logic [7:0] addr);
        return addr == glue_pkg::CONV_PORT;
    endfunction

    rd_state_e             rd_state;
    logic [BW-1:0]         byte_cnt;
    logic [RESULT_W-1:0]   word;
    logic                  pending;
    logic                  done_s1, done_s2, done_s3;
    logic                  trig_s1, trig_s2, trig_s3;
    logic [RESULT_W-1:0]   bus_s1, bus_s2;
    logic                  done_rise;
    logic                  trig_rise;
    logic                  clear_pending;
    logic                  io_sel;
    logic                  io_wait;
    logic                  start_req;
    logic                  byte_last;

    stream_if #(.W(RESULT_W)) fifo_in ();
    stream_if #(.W(RESULT_W)) fifo_out ();

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Converter pins are asynchronous; the third stage only feeds edge detection.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            done_s1 <= 1'b0;
            done_s2 <= 1'b0;
            done_s3 <= 1'b0;
            trig_s1 <= 1'b0;
            trig_s2 <= 1'b0;
            trig_s3 <= 1'b0;
            bus_s1  <= '0;
            bus_s2  <= '0;
        end else begin
            done_s1 <= conv_done;
            done_s2 <= done_s1;
            done_s3 <= done_s2;
            trig_s1 <= ext_trigger;
            trig_s2 <= trig_s1;
            trig_s3 <= trig_s2;
            bus_s1  <= result_bus;
            bus_s2  <= bus_s1;
        end
    end

    assign done_rise = done_s2 && !done_s3;
    assign trig_rise = trig_s2 && !trig_s3;

    // ------------------------------------------------------------
    // Host port with one wait state
    // ------------------------------------------------------------
    // The first cycle of a port access is a wait; the answer comes in the second.
    assign io_sel   = (io_rd || io_wr) && port_hit(io_addr);
    assign io_ready = !(io_sel && !io_wait);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            io_wait <= 1'b0;
        end else begin
            io_wait <= io_sel && !io_wait;
        end
    end

    // Read data carries FIFO status, latch status and the oldest result.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            io_rdata  <= '0;
            io_rvalid <= 1'b0;
        end else begin
            io_rvalid <= io_rd && port_hit(io_addr) && !io_wait;
            if (io_rd && port_hit(io_addr) && !io_wait) begin
                io_rdata                       <= '0;
                io_rdata[glue_pkg::STAT_VALID] <= fifo_out.valid;
                io_rdata[glue_pkg::STAT_PEND]  <= pending;
                io_rdata[RESULT_W-1:0]         <= fifo_out.data;
            end
        end
    end

    // A word leaves the FIFO when its answer cycle completes.
    assign fifo_out.ready = io_rd && port_hit(io_addr) && io_wait;

    // ------------------------------------------------------------
    // Conversion start
    // ------------------------------------------------------------
    // Port writes start conversions only in synchronous mode.
    assign start_req = async_mode ? trig_rise : (io_wr && port_hit(io_addr) && io_wait);

    start_pacer #(
        .PULSE_CYC (int'(glue_pkg::START_PULSE_CYC)),
        .GAP_CYC   (int'(glue_pkg::START_GAP_CYC))
    ) u_pacer (
        .clk             (clk),
        .rst             (rst),
        .request         (start_req),
        .convert_start_n (convert_start_n),
        .refused         (start_refused)
    );

    // ------------------------------------------------------------
    // Pending latch and requests
    // ------------------------------------------------------------
    assign clear_pending = (rd_state == R_HI_SEL);

    // Completion sets the latch; a set in the clearing cycle wins.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pending <= 1'b0;
            overrun <= 1'b0;
        end else begin
            overrun <= done_rise && pending && !clear_pending;
            if (done_rise) begin
                pending <= 1'b1;
            end else if (clear_pending) begin
                pending <= 1'b0;
            end
        end
    end

    assign dma_request_channel_one = pending;
    assign irq                     = pending;

    // ------------------------------------------------------------
    // Result read sequencer
    // ------------------------------------------------------------
    assign byte_last = (byte_cnt == BW'(1));

    // Reads start only when the FIFO has room, so a word is never dropped.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_state <= R_IDLE;
            byte_cnt <= '0;
        end else begin
            case (rd_state)
                R_IDLE: begin
                    if (pending && fifo_in.ready) begin
                        rd_state <= R_HI_SEL;
                    end
                end
                R_HI_SEL: begin
                    rd_state <= R_HI;
                    byte_cnt <= BW'(glue_pkg::BYTE_READ_CYC);
                end
                R_HI: begin
                    byte_cnt <= byte_cnt - BW'(1);
                    if (byte_last) begin
                        rd_state <= read_width_12 ? R_PUSH : R_LO_SEL;
                    end
                end
                R_LO_SEL: begin
                    rd_state <= R_LO;
                    byte_cnt <= BW'(glue_pkg::BYTE_READ_CYC);
                end
                R_LO: begin
                    byte_cnt <= byte_cnt - BW'(1);
                    if (byte_last) begin
                        rd_state <= R_PUSH;
                    end
                end
                R_PUSH: begin
                    if (fifo_in.ready) begin
                        rd_state <= R_IDLE;
                    end
                end
                default: begin
                    rd_state <= R_IDLE;
                end
            endcase
        end
    end

    // Bus samples are taken on the last cycle of each read window.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            word <= '0;
        end else if (rd_state == R_HI && byte_last) begin
            if (read_width_12) begin
                word <= bus_s2;
            end else begin
                word[RESULT_W-1:glue_pkg::LOW_W] <= bus_s2[glue_pkg::BYTE_W-1:0];
            end
        end else if (rd_state == R_LO && byte_last) begin
            word[glue_pkg::LOW_W-1:0] <= bus_s2[glue_pkg::BYTE_W-1:glue_pkg::BYTE_W-glue_pkg::LOW_W];
        end
    end

    // Converter pin drive, all from flip-flops.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            output_enable_n     <= 1'b1;
            host_flag_output    <= 1'b1;
            upper_byte_select_n <= 1'b1;
            read_width_12       <= 1'b0;
        end else begin
            output_enable_n     <= !((rd_state == R_HI_SEL) || (rd_state == R_LO_SEL) ||
                                     ((rd_state == R_HI || rd_state == R_LO) && !byte_last));
            host_flag_output    <= !((rd_state == R_IDLE && pending && fifo_in.ready) || rd_state == R_HI_SEL ||
                                     (rd_state == R_HI && !byte_last));
            upper_byte_select_n <= !(rd_state == R_IDLE && pending && fifo_in.ready);
            if (rd_state == R_IDLE) begin
                read_width_12 <= wide_mode;
            end
        end
    end

    assign fifo_in.valid = (rd_state == R_PUSH);
    assign fifo_in.data  = word;

    result_fifo #(
        .W     (RESULT_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk   (clk),
        .rst   (rst),
        .fill  (fifo_in),
        .drain (fifo_out)
    );

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    localparam logic [7:0] GAP_SAT = 8'hFF;
    localparam int         GAP_MIN = int'(glue_pkg::START_GAP_CYC);
    logic [7:0] gap_seen;

    // Cycles since the last start pulse began, saturating.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gap_seen <= GAP_SAT;
        end else if ($fell(convert_start_n)) begin
            gap_seen <= 8'h01;
        end else if (gap_seen != GAP_SAT) begin
            gap_seen <= gap_seen + 8'h01;
        end
    end

    property p_start_width;
        @(posedge clk) disable iff (rst) $fell(convert_start_n) |-> (!convert_start_n)[*4] ##1 convert_start_n;
    endproperty
    a_start_width: assert property (p_start_width) else $error("start pulse width wrong");

    property p_start_gap;
        @(posedge clk) disable iff (rst) $fell(convert_start_n) |-> gap_seen >= GAP_MIN;
    endproperty
    a_start_gap: assert property (p_start_gap) else $error("start pulses too close");

    property p_port_start;
        @(posedge clk) disable iff (rst) (start_req && gap_seen >= GAP_MIN && convert_start_n) |=> !convert_start_n;
    endproperty
    a_port_start: assert property (p_port_start) else $error("start request not honoured");

    property p_wait_state;
        @(posedge clk) disable iff (rst) (io_sel && !io_wait) |-> !io_ready ##1 (io_ready || !io_sel);
    endproperty
    a_wait_state: assert property (p_wait_state) else $error("wait state count wrong");

    property p_read_answer;
        @(posedge clk) disable iff (rst) (io_rd && port_hit(io_addr) && !io_wait) |=> io_rvalid && io_ready;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("port read not answered");

    property p_latch_set;
        @(posedge clk) disable iff (rst) done_rise |=> pending && dma_request_channel_one && irq;
    endproperty
    a_latch_set: assert property (p_latch_set) else $error("completion not latched");

    property p_latch_hold;
        @(posedge clk) disable iff (rst) (pending && !clear_pending) |=> pending;
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("pending lost before read");

    property p_flag_first;
        @(posedge clk) disable iff (rst) ($fell(output_enable_n) && !host_flag_output) |-> !$past(host_flag_output);
    endproperty
    a_flag_first: assert property (p_flag_first) else $error("flag not low before high read");

    property p_byte_window;
        @(posedge clk) disable iff (rst) $fell(output_enable_n) |-> (!output_enable_n)[*7] ##1 output_enable_n;
    endproperty
    a_byte_window: assert property (p_byte_window) else $error("byte read window wrong");

    property p_low_follows;
        @(posedge clk) disable iff (rst) ($rose(output_enable_n) && !read_width_12 && rd_state == R_LO_SEL)
            |=> !output_enable_n && host_flag_output;
    endproperty
    a_low_follows: assert property (p_low_follows) else $error("low byte read missing");

    property p_hbe_release;
        @(posedge clk) disable iff (rst) $fell(upper_byte_select_n) |=> upper_byte_select_n;
    endproperty
    a_hbe_release: assert property (p_hbe_release) else $error("upper select not released");

    c_byte_read: cover property (@(posedge clk) disable iff (rst) rd_state == R_LO && byte_last);
    c_wide_read: cover property (@(posedge clk) disable iff (rst) rd_state == R_PUSH && read_width_12);
    c_fifo_full: cover property (@(posedge clk) disable iff (rst) pending && !fifo_in.ready);
    c_refused:   cover property (@(posedge clk) disable iff (rst) start_refused);
endmodule

//--- hw/glue_pkg.sv
/*
 * Constants shared by the converter host glue: port decode, cycle counts and widths.
 * Assumes a 40 MHz system clock (25 ns period).
 */
package glue_pkg;
    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS  = 25000;
    localparam int unsigned START_PULSE_NS = 100;
    localparam int unsigned START_GAP_US   = 5;
    localparam int unsigned BYTE_READ_NS   = 160;
    // Least times round up to whole cycles.
    localparam int unsigned START_PULSE_CYC = (START_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned START_GAP_CYC   = (START_GAP_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned BYTE_READ_CYC   = (BYTE_READ_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // ------------------------------------------------------------
    // Decode and data layout
    // ------------------------------------------------------------
    localparam logic [7:0]  CONV_PORT   = 8'h08;
    localparam int unsigned RESULT_W    = 12;
    localparam int unsigned BYTE_W      = 8;
    localparam int unsigned LOW_W       = RESULT_W - BYTE_W;
    localparam int unsigned FIFO_DEPTH  = 8;
    localparam int unsigned RDATA_W     = 16;
    localparam int unsigned STAT_VALID  = 15;
    localparam int unsigned STAT_PEND   = 14;
endpackage

//--- hw/result_fifo.sv
/*
 * Synchronous FIFO of conversion results with valid/ready on both sides.
 * Assumes one clock and an asynchronous active-high reset.
 */
`timescale 1ns/1ps
module result_fifo #(
    parameter int W     = 12,
    parameter int DEPTH = 8
) (
    input  wire logic clk,
    input  wire logic rst,
    stream_if.snk     fill,
    stream_if.src     drain
);
    localparam int AW = $clog2(DEPTH);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("result_fifo depth must be a power of two of at least 2");
    end
    if (W < 1) begin : g_bad_width
        $error("result_fifo width must be positive");
    end

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   count;
    logic          do_push;
    logic          do_pop;

    // Full and empty follow the occupancy count exactly.
    assign fill.ready  = (count != AW'(0) + (AW+1)'(DEPTH));
    assign drain.valid = (count != '0);
    assign drain.data  = mem[rd_ptr];
    assign do_push     = fill.valid && fill.ready;
    assign do_pop      = drain.valid && drain.ready;

    // Storage write.
    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[wr_ptr] <= fill.data;
        end
    end

    // Pointers and occupancy.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (do_push) begin
                wr_ptr <= wr_ptr + AW'(1);
            end
            if (do_pop) begin
                rd_ptr <= rd_ptr + AW'(1);
            end
            if (do_push && !do_pop) begin
                count <= count + (AW+1)'(1);
            end else if (do_pop && !do_push) begin
                count <= count - (AW+1)'(1);
            end
        end
    end
endmodule

//--- hw/start_pacer.sv
/*
 * Turns start requests into timed active-low start pulses and refuses requests that come too soon.
 * Assumes requests are one-cycle pulses on the module clock.
 */
`timescale 1ns/1ps
module start_pacer #(
    parameter int PULSE_CYC = 4,
    parameter int GAP_CYC   = 200
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic request,
    output logic      convert_start_n,
    output logic      refused
);
    localparam int PW = $clog2(PULSE_CYC + 1);
    localparam int GW = $clog2(GAP_CYC + 1);

    if (PULSE_CYC < 1 || GAP_CYC <= PULSE_CYC) begin : g_bad_timing
        $error("start_pacer needs a pulse of one cycle or more, shorter than the gap");
    end

    logic [PW-1:0] pulse_cnt;
    logic [GW-1:0] gap_cnt;
    logic          fire;

    // A request is honoured only once the previous start is old enough.
    assign fire = request && (gap_cnt == '0);

    // Start pulse width.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pulse_cnt       <= '0;
            convert_start_n <= 1'b1;
        end else if (fire) begin
            pulse_cnt       <= PW'(PULSE_CYC);
            convert_start_n <= 1'b0;
        end else if (pulse_cnt != '0) begin
            pulse_cnt <= pulse_cnt - PW'(1);
            if (pulse_cnt == PW'(1)) begin
                convert_start_n <= 1'b1;
            end
        end
    end

    // Spacing between starts, and the refusal flag.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gap_cnt <= '0;
            refused <= 1'b0;
        end else begin
            refused <= request && !fire;
            if (fire) begin
                gap_cnt <= GW'(GAP_CYC - 1);
            end else if (gap_cnt != '0) begin
                gap_cnt <= gap_cnt - GW'(1);
            end
        end
    end
endmodule

//--- hw/stream_if.sv
/*
 * Valid/ready word carrier between the glue's own modules.
 * Assumes both ends share one clock.
 */
`timescale 1ns/1ps
interface stream_if #(
    parameter int W = 12
);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

//--- verification/adc_model.sv
/* Behavioural converter model for the host glue bench.
   Assumes the bench supplies the next sample value. */
`timescale 1ns/1ps
module adc_model #(
    parameter int CONV_NS = 2000
) (
    input  wire logic        convert_start_n,
    input  wire logic        output_enable_n,
    input  wire logic        host_flag_output,
    input  wire logic        read_width_12,
    input  wire logic [11:0] sample,
    output logic             conv_done,
    output logic [11:0]      result_bus
);
    logic [11:0] held = 12'h000;
    // A start fall begins a conversion; done rises at its end.
    always @(negedge convert_start_n) begin
        conv_done = 1'b0;
        #(CONV_NS);
        held = sample;
        conv_done = 1'b1;
    end
    initial conv_done = 1'b0;
    // A released bus shows the inverse word, so stale reads show up.
    always @* begin
        result_bus = output_enable_n ? ~held : read_width_12 ? held :
            host_flag_output ? {~held[11:8], held[3:0], 4'h0} : {~held[11:8], held[11:4]};
    end
endmodule

//--- verification/test_converter_host_glue.sv
/* Self-checking bench for the converter host glue.
   Assumes the converter model and a 40 MHz clock. */
`timescale 1ns/1ps
module test_converter_host_glue;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        io_rd = 1'b0;
    logic        io_wr = 1'b0;
    logic [7:0]  io_addr = 8'h08;
    logic        async_mode = 1'b0;
    logic        ext_trigger = 1'b0;
    logic        wide_mode = 1'b0;
    logic [11:0] sample = 12'h000;
    logic        io_ready, io_rvalid, convert_start_n, output_enable_n, host_flag_output, upper_byte_select_n;
    logic        read_width_12, dma_request_channel_one, irq, start_refused, overrun, conv_done;
    logic [11:0] result_bus;
    logic [15:0] io_rdata;
    logic [15:0] d;
    int          err_count = 0;
    int          tests_run = 0;
    int          ov_n = 0;
    int          n;
    // Clock of 25 ns.
    always #12.5 clk = ~clk;
    // Counts overrun pulses where the design output has settled.
    always @(negedge clk) if (overrun === 1'b1) ov_n++;
    converter_host_glue i_dut (.clk, .rst, .io_rd, .io_wr, .io_addr, .io_ready, .io_rdata, .io_rvalid,
        .async_mode, .ext_trigger, .wide_mode, .conv_done, .result_bus, .convert_start_n, .output_enable_n,
        .host_flag_output, .upper_byte_select_n, .read_width_12, .dma_request_channel_one, .irq,
        .start_refused, .overrun);
    adc_model i_adc (.convert_start_n, .output_enable_n, .host_flag_output, .read_width_12, .sample,
        .conv_done, .result_bus);
    task automatic close_out();
        $display("err_count=%0d tests_run=%0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Waits a bounded number of cycles for a level; a miss ends the run.
    task automatic wait_for(ref logic f, input logic v, input int lim);
        for (int i = 0; i < lim && f !== v; i++) @(negedge clk);
        chk(16'(f === v), 16'h1);
        if (f !== v) close_out();
    endtask
    // Counts the cycles a low pulse lasts.
    task automatic low_len(ref logic f);
        n = 0;
        while (f === 1'b0 && n < 20) begin
            n++;
            @(negedge clk);
        end
    endtask
    // One port 8 access, held until ready is seen high.
    task automatic port(input logic wr, output logic [15:0] q);
        logic w;
        io_rd = ~wr;
        io_wr = wr;
        #1 w = io_ready;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (io_ready !== 1'b1 && n < 8);
        q = io_rdata;
        chk({14'h0, w, io_rvalid}, {15'h0, ~wr});
        chk(16'(n), 16'h1);
        if (n == 8) close_out();
        @(negedge clk);
        io_rd = 1'b0;
        io_wr = 1'b0;
    endtask
    // Port start, early start refused, then a byte-mode read of the result.
    task automatic scn_byte_read();
        sample = 12'hA5C;
        port(1'b1, d);
        chk({15'h0, start_refused}, 16'h0);
        low_len(convert_start_n);
        chk(16'(n), 16'h4);
        port(1'b1, d);
        chk({14'h0, start_refused, convert_start_n}, 16'h3);
        wait_for(irq, 1'b1, 300);
        chk({15'h0, dma_request_channel_one}, 16'h1);
        wait_for(host_flag_output, 1'b0, 30);
        chk({14'h0, upper_byte_select_n, output_enable_n}, 16'h1);
        wait_for(output_enable_n, 1'b0, 4);
        chk({13'h0, host_flag_output, upper_byte_select_n, irq}, 16'h2);
        low_len(output_enable_n);
        chk({host_flag_output, 15'(n)}, 16'h8007);
        wait_for(output_enable_n, 1'b0, 4);
        low_len(output_enable_n);
        chk(16'(n), 16'h7);
        repeat (4) @(negedge clk);
        port(1'b0, d);
        chk(d, 16'h8A5C);
        @(negedge clk);
        port(1'b0, d);
        chk({14'h0, d[15:14]}, 16'h0);
        @(negedge clk);
        io_addr = 8'h09;
        io_wr = 1'b1;
        #1 chk({15'h0, io_ready}, 16'h1);
        @(negedge clk);
        io_wr = 1'b0;
        io_addr = 8'h08;
    endtask
    // Single 12-bit read in wide mode.
    task automatic scn_wide_read();
        wide_mode = 1'b1;
        sample = 12'h3E7;
        repeat (210) @(negedge clk);
        port(1'b1, d);
        wait_for(irq, 1'b1, 300);
        wait_for(output_enable_n, 1'b0, 6);
        chk({15'h0, read_width_12}, 16'h1);
        repeat (12) @(negedge clk);
        port(1'b0, d);
        chk(d, 16'h83E7);
    endtask
    // Trigger-started conversions in asynchronous mode, one more than the FIFO and latch can hold.
    task automatic scn_async();
        async_mode = 1'b1;
        repeat (210) @(negedge clk);
        port(1'b1, d);
        repeat (150) @(negedge clk);
        chk({15'h0, irq}, 16'h0);
        for (int k = 0; k < 10; k++) begin
            sample = 12'h111 * 12'(k + 1);
            ext_trigger = 1'b1;
            repeat (4) @(negedge clk);
            ext_trigger = 1'b0;
            repeat (210) @(negedge clk);
        end
        chk({15'h0, irq}, 16'h1);
        chk(16'(ov_n), 16'h1);
        // The ninth word is read after the tenth conversion has overwritten the converter output.
        for (int k = 0; k < 9; k++) begin
            port(1'b0, d);
            chk({d[15], 3'h0, d[11:0]}, {4'h8, 12'h111 * 12'(k + 1 + int'(k == 8))});
            repeat (6) @(negedge clk);
        end
    endtask
    // Main sequence: reset, idle pin levels, then each scenario in turn.
    initial begin
        repeat (4) @(negedge clk);
        rst = 1'b0;
        chk({10'h0, convert_start_n, output_enable_n, host_flag_output, upper_byte_select_n, irq, io_rvalid}, 16'h3C);
        scn_byte_read();
        scn_wide_read();
        scn_async();
        close_out();
    end
endmodule
